// file: afe_status_flags.sv
/*
 Status flag word of the front end: collects event flags from neighbouring
 blocks, holds them as each flag demands and serves them to the host over
 the serial port. Assumes all source signals are on the device clock and
 the serial pins come from the host asynchronously.
*/
//
// Notes on behaviour
// - Read-only 24-bit word at address 0x01; writes leave it untouched.
// - Flags reflect their sources regardless of any interrupt enables.
// - Every flag reads one when flagged, zero otherwise.
// - Lowest byte carries detail bits qualifying the interrupt flags.
// - Bit 23 high while ECG record count meets the ECG threshold.
// - Bit 22 sets on ECG overflow, clears on FIFO reset or resync.
// - Bit 21 sets on fast recovery; clearing follows its clear mode.
// - Bit 20 sets after DC lead-off over 90ms; held until readback.
// - Bit 19 high while impedance record count meets its threshold.
// - Bit 18 sets on impedance overflow, clears on FIFO reset or resync.
// - Bit 17 sets after impedance above high limit 100ms; held.
// - Bit 16 sets after impedance below low limit 128ms; held.
// - Bit 15 sets after either drive source detached 128ms; held.
// - Bit 11 sets on leads attached; held until readback.
// - Enabling attach detection sets bit 11; detection arms after a read.
// - Bit 10 sets on R event; clearing follows two-bit clear mode.
// - Held flags clear at 32nd serial clock, only if condition ended.
// - Bit 9 pulses on divided base-rate tick; own clear mode.
// - Bit 8 set while loop powered and unlocked; held until readback.
// - Bits 5 and 4 report positive and negative drive detach 128ms.
// - Bits 3 to 0 report input limit details together with bit 20.
`timescale 1ns/1ps
`default_nettype none

`include "afe_status_consts.svh"

module afe_status_flags #(
   parameter int unsigned FIFO_LEVEL_W = 6,
   parameter int unsigned DC_DETACH_CYCLES =
      `DC_DETACH_MS * `CYCLES_PER_MS + 1,
   parameter int unsigned IMP_ABOVE_CYCLES = `IMP_ABOVE_MS * `CYCLES_PER_MS,
   parameter int unsigned IMP_BELOW_CYCLES = `IMP_BELOW_MS * `CYCLES_PER_MS,
   parameter int unsigned DRIVE_DETACH_CYCLES =
      `DRIVE_DETACH_MS * `CYCLES_PER_MS,
   parameter int unsigned SELF_CLEAR_CYCLES =
      `SELF_CLEAR_US * `CYCLES_PER_US
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic SDI_I,
   output logic SDO_O,
   output logic SDO_OE_O,
   input wire logic [FIFO_LEVEL_W-1:0] ECG_FIFO_LEVEL_I,
   input wire logic [FIFO_LEVEL_W-1:0] ECG_FIFO_LEVEL_THRESHOLD_I,
   input wire logic ECG_FIFO_OVERRUN_I,
   input wire logic [FIFO_LEVEL_W-1:0] IMP_FIFO_LEVEL_I,
   input wire logic [FIFO_LEVEL_W-1:0] IMP_FIFO_LEVEL_THRESHOLD_I,
   input wire logic IMP_FIFO_OVERRUN_I,
   input wire logic FIFO_RESET_I,
   input wire logic RESYNC_COMMAND_I,
   input wire logic FAST_RECOVERY_ACTIVE_I,
   input wire logic FAST_RECOVERY_CLEAR_MODE_I,
   input wire logic [3:0] DC_INPUT_DETACH_I,
   input wire logic IMP_ABOVE_LIMIT_I,
   input wire logic IMP_BELOW_LIMIT_I,
   input wire logic POS_CURRENT_DRIVE_DETACH_I,
   input wire logic NEG_CURRENT_DRIVE_DETACH_I,
   input wire logic [1:0] LOW_POWER_ATTACH_DETECT_SELECT_I,
   input wire logic LEADS_ATTACH_I,
   input wire logic R_EVENT_I,
   input wire logic [1:0] R_EVENT_CLEAR_MODE_I,
   input wire logic R_INTERVAL_READ_I,
   input wire logic BASE_RATE_TICK_I,
   input wire logic [1:0] TICK_RATE_SELECT_I,
   input wire logic TICK_CLEAR_MODE_I,
   input wire logic ECG_ENABLE_I,
   input wire logic IMP_ENABLE_I,
   input wire logic LOOP_UNLOCKED_I,
   output logic [`STATUS_W-1:0] STATUS_O
);

   localparam int NQ = 7;
   localparam int unsigned Q_CYCLES [NQ] = '{DC_DETACH_CYCLES,
      IMP_ABOVE_CYCLES, IMP_BELOW_CYCLES, DRIVE_DETACH_CYCLES,
      DRIVE_DETACH_CYCLES, SELF_CLEAR_CYCLES, SELF_CLEAR_CYCLES};

   afe_status_pkg::status_word_t flag_reg;
   afe_status_pkg::status_word_t snap_reg;
   afe_status_pkg::status_word_t set_vec;
   afe_status_pkg::status_word_t clr_vec;
   afe_status_pkg::r_clear_mode_e r_mode;
   logic [NQ-1:0] q_cond;
   logic [NQ-1:0] q_done;
   logic load;
   logic done;
   logic [1:0] attach_mode_reg;
   logic armed_reg;
   logic [2:0] tick_cnt_reg;
   logic [2:0] tick_mask;
   logic tick_event;
   logic attach_enable_event;
   logic attach_enabled;

   if (FIFO_LEVEL_W < 1 || FIFO_LEVEL_W > 16) begin : g_check
      $error("FIFO_LEVEL_W must lie between 1 and 16");
   end

   status_spi_port u_port (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .sclk_i(SCLK_I),
      .cs_n_i(CS_N_I),
      .sdi_i(SDI_I),
      .status_i(flag_reg),
      .sdo_o(SDO_O),
      .sdo_oe_o(SDO_OE_O),
      .load_o(load),
      .done_o(done)
   );

   // The self-clearing flags time their own high period.
   assign q_cond = {flag_reg[`BIT_TICK], flag_reg[`BIT_R_EVENT],
      NEG_CURRENT_DRIVE_DETACH_I, POS_CURRENT_DRIVE_DETACH_I,
      IMP_BELOW_LIMIT_I, IMP_ABOVE_LIMIT_I, |DC_INPUT_DETACH_I};

   for (genvar i = 0; i < NQ; i++) begin : g_qual
      duration_qualifier #(
         .CYCLES(Q_CYCLES[i])
      ) u_qual (
         .clk_i(CLOCK_I),
         .rst_i(RST_I),
         .cond_i(q_cond[i]),
         .qualified_o(q_done[i])
      );
   end

   // Only bits actually shifted out are cleared, so an event that lands
   // after the word was captured is never lost.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         snap_reg <= `STATUS_RESET;
      end else if (load) begin
         snap_reg <= flag_reg;
      end
   end

   assign attach_enabled = (LOW_POWER_ATTACH_DETECT_SELECT_I != `MODE_OFF) &&
      (LOW_POWER_ATTACH_DETECT_SELECT_I != `MODE_RESERVED);
   assign attach_enable_event = attach_enabled &&
      (attach_mode_reg != LOW_POWER_ATTACH_DETECT_SELECT_I);

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         attach_mode_reg <= `MODE_OFF;
      end else begin
         attach_mode_reg <= LOW_POWER_ATTACH_DETECT_SELECT_I;
      end
   end

   // Detection stays disarmed until the host reads the word once.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I || !attach_enabled || attach_enable_event) begin
         armed_reg <= 1'b0;
      end else if (done && snap_reg[`BIT_ATTACH]) begin
         armed_reg <= 1'b1;
      end
   end

   always_comb begin
      unique case (TICK_RATE_SELECT_I)
         2'h0: tick_mask = 3'h0;
         2'h1: tick_mask = 3'h1;
         2'h2: tick_mask = 3'h3;
         2'h3: tick_mask = 3'h7;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         tick_cnt_reg <= 3'h0;
      end else if (BASE_RATE_TICK_I) begin
         tick_cnt_reg <= tick_cnt_reg + 3'h1;
      end
   end

   assign tick_event = BASE_RATE_TICK_I && ((tick_cnt_reg & tick_mask) == 3'h0);
   assign r_mode = afe_status_pkg::r_clear_mode_e'(R_EVENT_CLEAR_MODE_I);

   always_comb begin
      set_vec = `STATUS_RESET;
      clr_vec = ~`STATUS_RESET;
      set_vec[`BIT_ECG_THR] = ECG_FIFO_LEVEL_I >= ECG_FIFO_LEVEL_THRESHOLD_I;
      clr_vec[`BIT_ECG_THR] = 1'b1;
      set_vec[`BIT_ECG_OVF] = ECG_FIFO_OVERRUN_I;
      clr_vec[`BIT_ECG_OVF] = FIFO_RESET_I || RESYNC_COMMAND_I;
      set_vec[`BIT_FAST] = FAST_RECOVERY_ACTIVE_I;
      clr_vec[`BIT_FAST] = FAST_RECOVERY_CLEAR_MODE_I ? 1'b1 :
         done && snap_reg[`BIT_FAST];
      set_vec[`BIT_DC] = q_done[0];
      set_vec[`BIT_IMP_THR] = IMP_FIFO_LEVEL_I >= IMP_FIFO_LEVEL_THRESHOLD_I;
      clr_vec[`BIT_IMP_THR] = 1'b1;
      set_vec[`BIT_IMP_OVF] = IMP_FIFO_OVERRUN_I;
      clr_vec[`BIT_IMP_OVF] = FIFO_RESET_I || RESYNC_COMMAND_I;
      set_vec[`BIT_IMP_ABOVE] = q_done[1];
      set_vec[`BIT_IMP_BELOW] = q_done[2];
      set_vec[`BIT_DRIVE] = q_done[3] || q_done[4];
      set_vec[`BIT_POS_DRIVE] = q_done[3];
      set_vec[`BIT_NEG_DRIVE] = q_done[4];
      set_vec[`BIT_ATTACH] = attach_enable_event || (armed_reg && LEADS_ATTACH_I);
      set_vec[`BIT_R_EVENT] = R_EVENT_I;
      unique case (r_mode)
         afe_status_pkg::R_CLR_SELF: clr_vec[`BIT_R_EVENT] = q_done[5];
         afe_status_pkg::R_CLR_ON_RTOR_READ:
            clr_vec[`BIT_R_EVENT] = R_INTERVAL_READ_I;
         afe_status_pkg::R_CLR_ON_READBACK,
         afe_status_pkg::R_CLR_SPARE:
            clr_vec[`BIT_R_EVENT] = done && snap_reg[`BIT_R_EVENT];
      endcase
      set_vec[`BIT_TICK] = tick_event;
      clr_vec[`BIT_TICK] = TICK_CLEAR_MODE_I ? q_done[6] :
         done && snap_reg[`BIT_TICK];
      set_vec[`BIT_UNLOCK] = LOOP_UNLOCKED_I && (ECG_ENABLE_I || IMP_ENABLE_I);
      for (int d = 0; d < 4; d++) begin
         set_vec[`BIT_DC_DETAIL + d] = q_done[0] && DC_INPUT_DETACH_I[d];
      end
      // Persistence-held flags, bit 11 and bit 8 share the readback clear.
      for (int b = 0; b < `STATUS_W; b++) begin
         if (b == `BIT_DC || b == `BIT_IMP_ABOVE || b == `BIT_IMP_BELOW ||
             b == `BIT_DRIVE || b == `BIT_ATTACH || b == `BIT_UNLOCK ||
             b == `BIT_POS_DRIVE || b == `BIT_NEG_DRIVE ||
             (b >= `BIT_DC_DETAIL && b < `BIT_DC_DETAIL + 4)) begin
            clr_vec[b] = done && snap_reg[b];
         end
      end
   end

   // Set wins over clear, so a level still present survives a readback.
   // Only bit 8 is gated, by the ECG and impedance enables; masking lives in the interrupt block.
   for (genvar b = 0; b < `STATUS_W; b++) begin : g_flag
      always_ff @(posedge CLOCK_I) begin
         if (RST_I) begin
            flag_reg[b] <= 1'b0;
         end else begin
            flag_reg[b] <= set_vec[b] || (flag_reg[b] && !clr_vec[b]);
         end
      end
   end

   // Top byte pair are interrupt flags, low byte only qualifies them.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         STATUS_O <= `STATUS_RESET;
      end else begin
         STATUS_O <= set_vec | (flag_reg & ~clr_vec);
      end
   end

endmodule

`default_nettype wire

// file: afe_status_consts.svh
/*
 Constants for the status flag word: register address, bit positions,
 serial frame positions and timing figures. Assumes a 100 MHz device clock.
*/
`ifndef AFE_STATUS_CONSTS_SVH
`define AFE_STATUS_CONSTS_SVH

`define STATUS_ADDR 7'h01
`define STATUS_W 24
`define STATUS_RESET 24'h000000
`define CLK_MHZ 100
`define CYCLES_PER_MS (`CLK_MHZ * 1000)
`define CYCLES_PER_US (`CLK_MHZ)
`define DC_DETACH_MS 90
`define IMP_ABOVE_MS 100
`define IMP_BELOW_MS 128
`define DRIVE_DETACH_MS 128
`define SELF_CLEAR_US 1

`define BIT_ECG_THR 23
`define BIT_ECG_OVF 22
`define BIT_FAST 21
`define BIT_DC 20
`define BIT_IMP_THR 19
`define BIT_IMP_OVF 18
`define BIT_IMP_ABOVE 17
`define BIT_IMP_BELOW 16
`define BIT_DRIVE 15
`define BIT_ATTACH 11
`define BIT_R_EVENT 10
`define BIT_TICK 9
`define BIT_UNLOCK 8
`define BIT_POS_DRIVE 5
`define BIT_NEG_DRIVE 4
`define BIT_DC_DETAIL 0

`define CMD_BITS 6'd8
`define LAST_CMD_CNT 6'd7
`define FIRST_SHIFT_CNT 6'd9
`define FRAME_BITS 6'd32
`define LAST_FRAME_CNT 6'd31
`define MODE_OFF 2'h0
`define MODE_RESERVED 2'h3

`endif

// file: afe_status_pkg.sv
/*
 Types shared by the status flag logic.
 Assumes the constants header is compiled alongside.
*/
package afe_status_pkg;

   typedef enum logic [1:0] {
      R_CLR_ON_READBACK = 2'h0,
      R_CLR_SELF = 2'h1,
      R_CLR_ON_RTOR_READ = 2'h2,
      R_CLR_SPARE = 2'h3
   } r_clear_mode_e;

   typedef logic [23:0] status_word_t;

endpackage

// file: duration_qualifier.sv
/*
 Duration qualifier: output rises once the input has stayed high for
 CYCLES consecutive clocks, and falls with the input.
 Assumes the input is already in the device clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module duration_qualifier #(
   parameter int unsigned CYCLES = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cond_i,
   output logic qualified_o
);

   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(CYCLES - 1);

   logic [CW-1:0] count_reg;

   if (CYCLES < 1) begin : g_check
      $error("duration_qualifier needs at least one cycle");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !cond_i) begin
         count_reg <= '0;
      end else if (count_reg != LIMIT) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         qualified_o <= 1'b0;
      end else begin
         qualified_o <= cond_i && (count_reg == LIMIT);
      end
   end

endmodule

`default_nettype wire

// file: status_spi_port.sv
/*
 Serial port front end for the status word. Samples the serial pins with
 the device clock, decodes a read of the status address and shifts the
 word out. Assumes command bits are taken on serial clock rising edges,
 address first, read/write bit last, and a clock well below 50 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

`include "afe_status_consts.svh"

module status_spi_port (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   input wire afe_status_pkg::status_word_t status_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic load_o,
   output logic done_o
);

   logic sclk_meta_reg;
   logic sclk_sync_reg;
   logic sclk_prev_reg;
   logic cs_meta_reg;
   logic cs_n_sync_reg;
   logic sdi_meta_reg;
   logic sdi_sync_reg;
   logic [5:0] count_reg;
   logic [6:0] addr_reg;
   logic selected_reg;
   afe_status_pkg::status_word_t shift_reg;
   logic rise;
   logic fall;

   // Two stages on every pin; the edge detector only sees the second.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_meta_reg <= 1'b0;
         sclk_sync_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         cs_meta_reg <= 1'b1;
         cs_n_sync_reg <= 1'b1;
         sdi_meta_reg <= 1'b0;
         sdi_sync_reg <= 1'b0;
      end else begin
         sclk_meta_reg <= sclk_i;
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg;
         cs_meta_reg <= cs_n_i;
         cs_n_sync_reg <= cs_meta_reg;
         sdi_meta_reg <= sdi_i;
         sdi_sync_reg <= sdi_meta_reg;
      end
   end

   assign rise = sclk_sync_reg && !sclk_prev_reg && !cs_n_sync_reg;
   assign fall = !sclk_sync_reg && sclk_prev_reg && !cs_n_sync_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_sync_reg) begin
         count_reg <= '0;
         addr_reg <= '0;
      end else if (rise) begin
         if (count_reg != `FRAME_BITS) begin
            count_reg <= count_reg + 1'b1;
         end
         if (count_reg < `LAST_CMD_CNT) begin
            addr_reg <= {addr_reg[5:0], sdi_sync_reg};
         end
      end
   end

   // Writes to the status address are simply not decoded.
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_sync_reg) begin
         selected_reg <= 1'b0;
         shift_reg <= `STATUS_RESET;
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else if (rise && count_reg == `LAST_CMD_CNT) begin
         selected_reg <= (addr_reg == `STATUS_ADDR) && sdi_sync_reg;
         sdo_oe_o <= (addr_reg == `STATUS_ADDR) && sdi_sync_reg;
      end else if (load_o) begin
         shift_reg <= status_i;
         sdo_o <= status_i[`STATUS_W-1];
      end else if (fall && selected_reg && count_reg >= `FIRST_SHIFT_CNT &&
                   count_reg <= `LAST_FRAME_CNT) begin
         sdo_o <= shift_reg[`STATUS_W-2];
         shift_reg <= {shift_reg[`STATUS_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         load_o <= rise && count_reg == `LAST_CMD_CNT &&
                   addr_reg == `STATUS_ADDR && sdi_sync_reg;
         done_o <= rise && selected_reg && count_reg == `LAST_FRAME_CNT;
      end
   end

endmodule

`default_nettype wire

// file: afe_status_flags_sva.sv
/*
 Checker for the status flag word, bound to its top module.
 Assumes the shortened DC detach count is handed on by the bind.
*/
`timescale 1ns/1ps
`default_nettype none

module afe_status_flags_sva #(
   parameter int unsigned FIFO_LEVEL_W = 6,
   parameter int unsigned DC_DETACH_CYCLES = 20
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CS_N_I,
   input wire logic SDO_O,
   input wire logic SDO_OE_O,
   input wire logic [FIFO_LEVEL_W-1:0] ECG_FIFO_LEVEL_I,
   input wire logic [FIFO_LEVEL_W-1:0] ECG_FIFO_LEVEL_THRESHOLD_I,
   input wire logic ECG_FIFO_OVERRUN_I,
   input wire logic IMP_FIFO_OVERRUN_I,
   input wire logic FIFO_RESET_I,
   input wire logic RESYNC_COMMAND_I,
   input wire logic FAST_RECOVERY_ACTIVE_I,
   input wire logic FAST_RECOVERY_CLEAR_MODE_I,
   input wire logic [3:0] DC_INPUT_DETACH_I,
   input wire logic [1:0] LOW_POWER_ATTACH_DETECT_SELECT_I,
   input wire logic R_EVENT_I,
   input wire logic [23:0] STATUS_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   logic [7:0] dc_run_reg;
   // Saturates so a long condition never wraps back into the window.
   always_ff @(posedge CLOCK_I) begin
      if (RST_I || DC_INPUT_DETACH_I == 4'h0) dc_run_reg <= 8'h00;
      else if (dc_run_reg != 8'hff) dc_run_reg <= dc_run_reg + 8'h01;
   end
   property p_reserved;
      STATUS_O[14:12] == 3'h0 && STATUS_O[7:6] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved");
   property p_ecg_thr;
      !$past(RST_I) |-> STATUS_O[23] ==
         ($past(ECG_FIFO_LEVEL_I) >= $past(ECG_FIFO_LEVEL_THRESHOLD_I));
   endproperty
   a_ecg_thr: assert property (p_ecg_thr) else $error("thr");
   property p_ovf_keep;
      ECG_FIFO_OVERRUN_I || (STATUS_O[22] && !FIFO_RESET_I &&
         !RESYNC_COMMAND_I) |=> STATUS_O[22];
   endproperty
   a_ovf_keep: assert property (p_ovf_keep) else $error("ovf");
   property p_ovf_clr;
      (FIFO_RESET_I || RESYNC_COMMAND_I) && !ECG_FIFO_OVERRUN_I
         |=> !STATUS_O[22];
   endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("ovf clr");
   property p_imp_ovf;
      IMP_FIFO_OVERRUN_I |=> STATUS_O[18];
   endproperty
   a_imp_ovf: assert property (p_imp_ovf) else $error("imp ovf");
   property p_r_event;
      R_EVENT_I |=> STATUS_O[10];
   endproperty
   a_r_event: assert property (p_r_event) else $error("r evt");
   property p_dc_late;
      dc_run_reg == DC_DETACH_CYCLES + 3 |-> STATUS_O[20] && STATUS_O[3:0]
         == (STATUS_O[3:0] | $past(DC_INPUT_DETACH_I));
   endproperty
   a_dc_late: assert property (p_dc_late) else $error("dc");
   property p_held_clear;
      $fell(STATUS_O[20]) || $fell(STATUS_O[17]) || $fell(STATUS_O[16]) ||
         $fell(STATUS_O[15]) |-> !CS_N_I;
   endproperty
   a_held_clear: assert property (p_held_clear) else $error("clr");
   property p_sdo_idle;
      CS_N_I && $past(CS_N_I) && $past(CS_N_I, 2) && $past(CS_N_I, 3) &&
         $past(CS_N_I, 5) |-> !SDO_OE_O && !SDO_O;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("sdo");
   property p_attach;
      LOW_POWER_ATTACH_DETECT_SELECT_I inside {2'h1, 2'h2} &&
         !($past(LOW_POWER_ATTACH_DETECT_SELECT_I) inside {2'h1, 2'h2})
         |-> ##[1:2] STATUS_O[11];
   endproperty
   a_attach: assert property (p_attach) else $error("attach");
   property p_fast;
      FAST_RECOVERY_CLEAR_MODE_I && $past(FAST_RECOVERY_CLEAR_MODE_I) &&
         !$past(RST_I) |-> STATUS_O[21] == $past(FAST_RECOVERY_ACTIVE_I);
   endproperty
   a_fast: assert property (p_fast) else $error("fast");
   c_read: cover property ($rose(SDO_OE_O));
   c_clear: cover property ($fell(STATUS_O[20]));
   c_dc: cover property (dc_run_reg == DC_DETACH_CYCLES + 3);
endmodule

bind afe_status_flags afe_status_flags_sva #(
   .FIFO_LEVEL_W(FIFO_LEVEL_W), .DC_DETACH_CYCLES(DC_DETACH_CYCLES)) u_sva (
   .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .SDO_O(SDO_O),
   .SDO_OE_O(SDO_OE_O), .ECG_FIFO_LEVEL_I(ECG_FIFO_LEVEL_I),
   .ECG_FIFO_LEVEL_THRESHOLD_I(ECG_FIFO_LEVEL_THRESHOLD_I),
   .ECG_FIFO_OVERRUN_I(ECG_FIFO_OVERRUN_I),
   .IMP_FIFO_OVERRUN_I(IMP_FIFO_OVERRUN_I), .FIFO_RESET_I(FIFO_RESET_I),
   .RESYNC_COMMAND_I(RESYNC_COMMAND_I),
   .FAST_RECOVERY_ACTIVE_I(FAST_RECOVERY_ACTIVE_I),
   .FAST_RECOVERY_CLEAR_MODE_I(FAST_RECOVERY_CLEAR_MODE_I),
   .DC_INPUT_DETACH_I(DC_INPUT_DETACH_I),
   .LOW_POWER_ATTACH_DETECT_SELECT_I(LOW_POWER_ATTACH_DETECT_SELECT_I),
   .R_EVENT_I(R_EVENT_I), .STATUS_O(STATUS_O));

`default_nettype wire

// file: host_spi_model.sv
/*
 Host model for the serial status port: runs whole 32-clock frames.
 Assumes the bench calls xfer just after a device clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module host_spi_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // Serial clock of 160 ns stands still low between frames.
   task automatic xfer(input logic [7:0] cmd, output logic [23:0] word,
      output logic oe_seen);
      word = 24'h0;
      oe_seen = 1'b0;
      #1;
      cs_n_o = 1'b0;
      for (int i = 0; i < 32; i++) begin
         sdi_o = (i < 8) ? cmd[7-i] : ~sdi_o;
         #80;
         if (i >= 8) begin
            word = {word[22:0], sdo_i};
            oe_seen = oe_seen | sdo_oe_i;
         end
         sclk_o = 1'b1;
         #80;
         sclk_o = 1'b0;
      end
      #80;
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #80;
   endtask
endmodule

`default_nettype wire

// file: tb_afe_status_flags.sv
/*
 Self-checking bench for the status flag word with a serial host model.
 Assumes short qualifier counts so the run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_afe_status_flags;
   localparam int DC = 20;
   localparam int DR = 50;
   localparam int SC = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, sdi, sdo, sdo_oe, oe;
   logic [5:0] ecg_lvl, ecg_thr, imp_lvl, imp_thr;
   logic ecg_ovf, imp_ovf, fifo_rst, resync, fast, fast_md, imp_hi, imp_lo;
   logic pos_det, neg_det, attach, r_ev, r_ird, tick, tick_md, ecg_en;
   logic imp_en, unlocked;
   logic [3:0] dc_det;
   logic [1:0] lp_sel, r_mode, tick_sel;
   logic [23:0] st, w, e;
   logic [31:0] r;
   int num_errors = 0;
   int cmp_count = 0;
   int seed = 32'h4942;
   int cnt;
   always #5 clk = ~clk;

   afe_status_flags #(.DC_DETACH_CYCLES(DC), .IMP_ABOVE_CYCLES(30),
      .IMP_BELOW_CYCLES(40), .DRIVE_DETACH_CYCLES(DR),
      .SELF_CLEAR_CYCLES(SC)) uut (
      .CLOCK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
      .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
      .ECG_FIFO_LEVEL_I(ecg_lvl), .ECG_FIFO_LEVEL_THRESHOLD_I(ecg_thr),
      .ECG_FIFO_OVERRUN_I(ecg_ovf), .IMP_FIFO_LEVEL_I(imp_lvl),
      .IMP_FIFO_LEVEL_THRESHOLD_I(imp_thr), .IMP_FIFO_OVERRUN_I(imp_ovf),
      .FIFO_RESET_I(fifo_rst), .RESYNC_COMMAND_I(resync),
      .FAST_RECOVERY_ACTIVE_I(fast), .FAST_RECOVERY_CLEAR_MODE_I(fast_md),
      .DC_INPUT_DETACH_I(dc_det), .IMP_ABOVE_LIMIT_I(imp_hi),
      .IMP_BELOW_LIMIT_I(imp_lo), .POS_CURRENT_DRIVE_DETACH_I(pos_det),
      .NEG_CURRENT_DRIVE_DETACH_I(neg_det),
      .LOW_POWER_ATTACH_DETECT_SELECT_I(lp_sel), .LEADS_ATTACH_I(attach),
      .R_EVENT_I(r_ev), .R_EVENT_CLEAR_MODE_I(r_mode),
      .R_INTERVAL_READ_I(r_ird), .BASE_RATE_TICK_I(tick),
      .TICK_RATE_SELECT_I(tick_sel), .TICK_CLEAR_MODE_I(tick_md),
      .ECG_ENABLE_I(ecg_en), .IMP_ENABLE_I(imp_en),
      .LOOP_UNLOCKED_I(unlocked), .STATUS_O(st));
   host_spi_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
      .sdo_i(sdo), .sdo_oe_i(sdo_oe));

   function automatic logic at_least(input logic [5:0] a, input logic [5:0] b);
      return a >= b;
   endfunction
   function automatic logic [23:0] held_exp(input int k, input logic [3:0] n);
      case (k)
         0: return {3'h0, 1'b1, 16'h0, n};
         1: return 24'h020000;
         2: return 24'h010000;
         3: return 24'h008020;
         default: return 24'h008010;
      endcase
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Looks at mid-cycle so the edge's updates have landed, then realigns.
   task automatic look(input int n, input logic [23:0] m, input logic [23:0] x);
      cyc(n);
      @(negedge clk);
      chk(st & m, x);
      @(posedge clk);
   endtask
   task automatic xf(input logic [7:0] c);
      host.xfer(c, w, oe);
      cyc(2);
   endtask
   task automatic set_cond(input int k, input logic [3:0] n);
      dc_det <= (k == 0) ? n : 4'h0;
      imp_hi <= (k == 1) && (n != 4'h0);
      imp_lo <= (k == 2) && (n != 4'h0);
      pos_det <= (k == 3) && (n != 4'h0);
      neg_det <= (k == 4) && (n != 4'h0);
   endtask
   task automatic conclude();
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #500000;
      num_errors++;
      conclude();
   end

   initial begin
      {ecg_lvl, ecg_thr, imp_lvl, imp_thr, ecg_ovf, imp_ovf, fifo_rst, resync,
         fast, fast_md, dc_det, imp_hi, imp_lo, pos_det, neg_det, attach,
         r_ev, r_ird, tick, tick_md, ecg_en, imp_en, unlocked, lp_sel,
         r_mode, tick_sel} = '0;
      cyc(20);
      rst <= 1'b0;
      cyc(4);
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         ecg_lvl <= r[5:0];
         ecg_thr <= i[0] ? r[5:0] : r[11:6];
         imp_lvl <= r[17:12];
         imp_thr <= i[1] ? r[17:12] : r[23:18];
         look(2, 24'h0070c0, 24'h0);
         chk(st[23], at_least(ecg_lvl, ecg_thr));
         chk(st[19], at_least(imp_lvl, imp_thr));
      end
      ecg_ovf <= 1'b1;
      imp_ovf <= 1'b1;
      cyc(1);
      ecg_ovf <= 1'b0;
      imp_ovf <= 1'b0;
      xf(8'h03);
      chk(w & 24'h440000, 24'h440000);
      xf(8'h02);
      chk(oe, 1'b0);
      xf(8'h05);
      chk({oe, w[22:0]}, 24'h0);
      look(0, 24'h440000, 24'h440000);
      fifo_rst <= 1'b1;
      imp_ovf <= 1'b1;
      cyc(1);
      fifo_rst <= 1'b0;
      imp_ovf <= 1'b0;
      look(2, 24'h440000, 24'h040000);
      resync <= 1'b1;
      cyc(1);
      resync <= 1'b0;
      look(2, 24'h440000, 24'h0);
      for (int k = 0; k < 5; k++) begin
         r = $random(seed);
         e = held_exp(k, r[3:0] | 4'h1);
         set_cond(k, r[3:0] | 4'h1);
         look(10, 24'h13803f, 24'h0);
         look(DR, 24'h13803f, e);
         xf(8'h03);
         chk(w & 24'h13803f, e);
         look(0, 24'h13803f, e);
         set_cond(k, 4'h0);
         look(3, 24'h13803f, e);
         xf(8'h03);
         look(0, 24'h13803f, 24'h0);
      end
      for (int m = 0; m < 4; m++) begin
         r_mode <= m[1:0];
         r_ev <= 1'b1;
         cyc(1);
         r_ev <= 1'b0;
         look(2, 24'h000400, 24'h000400);
         r_ird <= (m == 2);
         cyc(1);
         r_ird <= 1'b0;
         if (m != 1 && m != 2) xf(8'h03);
         look(SC + 4, 24'h000400, 24'h0);
      end
      fast_md <= 1'b1;
      fast <= 1'b1;
      look(3, 24'h200000, 24'h200000);
      fast <= 1'b0;
      look(3, 24'h200000, 24'h0);
      fast_md <= 1'b0;
      fast <= 1'b1;
      cyc(1);
      fast <= 1'b0;
      look(3, 24'h200000, 24'h200000);
      xf(8'h03);
      look(0, 24'h200000, 24'h0);
      lp_sel <= 2'h1;
      look(3, 24'h000800, 24'h000800);
      xf(8'h03);
      look(0, 24'h000800, 24'h0);
      attach <= 1'b1;
      look(3, 24'h000800, 24'h000800);
      attach <= 1'b0;
      look(3, 24'h000800, 24'h000800);
      xf(8'h03);
      look(0, 24'h000800, 24'h0);
      unlocked <= 1'b1;
      look(3, 24'h000100, 24'h0);
      ecg_en <= 1'b1;
      look(3, 24'h000100, 24'h000100);
      unlocked <= 1'b0;
      look(3, 24'h000100, 24'h000100);
      xf(8'h03);
      look(0, 24'h000100, 24'h0);
      tick_md <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         cnt = 0;
         for (int t = 0; t < 8; t++) begin
            tick_sel <= s[1:0];
            tick <= 1'b1;
            cyc(1);
            tick <= 1'b0;
            cyc(3);
            cnt += (st[9] === 1'b1);
            cyc(SC + 4);
         end
         chk(24'(cnt), 24'(8 >> s));
      end
      tick_md <= 1'b0;
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      look(SC + 4, 24'h000200, 24'h000200);
      xf(8'h03);
      look(0, 24'h000200, 24'h0);
      conclude();
   end
endmodule

`default_nettype wire
